// ---- ice_pkg.sv ----
// Constants and types for the inline tone extension parser
package ice_pkg;
    localparam logic [11:0] OFF_OP_MODE     = 12'h900;
    localparam logic [11:0] OFF_INLINE_CONF = 12'h904;
    localparam logic [11:0] OFF_SWITCH      = 12'h910;
    localparam logic [11:0] OFF_STATUS      = 12'h914;

    localparam logic [31:0] CONF_RST   = 32'h00002800;
    localparam logic [31:0] CONF_WMASK = 32'hFFFFFCC7;
    localparam logic [1:0]  OP_RST     = 2'h0;
    localparam logic [2:0]  SWITCH_RST = 3'h2;

    localparam int POS_PARSE_EN = 0;
    localparam int POS_INFO_S1  = 1;
    localparam int POS_CRC_FAIL = 2;
    localparam int POS_MAXDUR   = 6;
    localparam int POS_SHORT    = 10;
    localparam int POS_LONG     = 13;
    localparam int POS_PAT      = 16;
    localparam int POS_MASK     = 24;
    localparam int POS_SWITCH   = 8;
    localparam int POS_TYPE     = 6;

    localparam logic [5:0] LIM_DEFAULT = 6'h14;
    localparam logic [5:0] LIM_MID     = 6'h1F;
    localparam logic [5:0] LIM_MAX     = 6'h3F;
    localparam logic [5:0] MIN_LEGAL   = 6'h02;

    localparam logic [1:0] TYPE_DEP_1US = 2'h1;
    localparam logic [1:0] TYPE_DEP_2US = 2'h2;
    localparam logic [2:0] SW_4US       = 3'h1;
    localparam logic [2:0] SW_2US       = 3'h2;

    typedef enum logic [1:0] {
        OP_DISABLED = 2'h0,
        OP_DEPART   = 2'h2,
        OP_ARRIVE   = 2'h3
    } ice_op_t;

    typedef enum logic {
        ST_IDLE,
        ST_WAIT_CRC
    } ice_state_t;
endpackage

// ---- ice_parse_if.sv ----
// Signals shared between the parser top and its match and clamp helpers
`timescale 1ns/100ps
`default_nettype none
interface ice_parse_if;
    logic [7:0] hdrField;
    logic [7:0] pattern;
    logic [7:0] mask;
    logic       hit;
    logic [5:0] rawTime;
    logic [1:0] limitSel;
    logic [5:0] clampedTime;
    logic       suspect;

    modport top     (output hdrField, pattern, mask, rawTime, limitSel,
                     input hit, clampedTime, suspect);
    modport matcher (input hdrField, pattern, mask, output hit);
    modport clamper (input rawTime, limitSel, output clampedTime, suspect);
endinterface
`default_nettype wire

// ---- ice_hdr_match.sv ----
// Masked compare of the first header field against a pattern
`timescale 1ns/100ps
`default_nettype none
module ice_hdr_match
    import ice_pkg::*;
(
    ice_parse_if.matcher p   // Header, pattern, mask in; hit out
);
    // Bit 0 is the first bit on air on all three vectors
    assign p.hit = ((p.hdrField ^ p.pattern) & p.mask) == 8'h00;
endmodule
`default_nettype wire

// ---- ice_dur_clamp.sv ----
// Limits the parsed tone duration and flags implausible values
`timescale 1ns/100ps
`default_nettype none
module ice_dur_clamp
    import ice_pkg::*;
(
    ice_parse_if.clamper p   // Raw duration and limit code in; result out
);
    logic [5:0] limit;

    always_comb begin
        case (p.limitSel)
            2'h1:    limit = LIM_MID;
            2'h2:    limit = LIM_MAX;
            default: limit = LIM_DEFAULT;
        endcase
    end

    assign p.clampedTime = (p.rawTime > limit) ? limit : p.rawTime;
    // Outside the legal span, whatever limit is chosen
    assign p.suspect = (p.rawTime > LIM_DEFAULT) || (p.rawTime < MIN_LEGAL);
endmodule
`default_nettype wire

// ---- ice_inline_cfg.sv ----
// Inline tone extension configuration, header parsing and spacing choice
// Function
// - Location bit 1 reads info from second header byte; 0 does not.
// - Error bit 1 samples after CRC failure; 0 skips sampling then.
// - Duration limit code 0 gives 20, 1 gives 31, 2 gives 63.
// - With limit 20, durations above 20 are replaced by 20.
// - Legal durations are 2 to 20; others flag a suspect packet.
// - Spacing codes 1 to 6 mean 4, 2, 1, 0.5, 0.25, 0.125 us.
// - Short field used for departure 1 us type, or arrival 2 us switching.
// - Long field used for departure 2 us type, or arrival 4 us switching.
// - First header field compared with pattern, bit 0 first on air.
// - Mask bits choose which header bits join the compare.
// - Op mode 0 off, 2 departure, 3 arrival; picks the spacing condition.
`timescale 1ns/100ps
`default_nettype none
module ice_inline_cfg
    import ice_pkg::*;
(
    input  wire logic        clk,              // 200 MHz clock
    input  wire logic        rstn,             // Synchronous reset, low
    input  wire logic [11:0] regAddr,          // Register byte address
    input  wire logic [31:0] regWdata,         // Write data
    input  wire logic        regWrite,         // Write strobe
    input  wire logic        regRead,          // Read strobe
    output logic      [31:0] regRdata,         // Read data, next cycle
    input  wire logic        hdrStrobe,        // Header bytes valid
    input  wire logic [7:0]  firstHeaderField, // First header field
    input  wire logic [7:0]  secondHeaderByte, // Second header byte
    input  wire logic        advInfoValid,     // Extended header info present
    input  wire logic [7:0]  advInfo,          // Info from extended header
    input  wire logic        crcStrobe,        // CRC result valid
    input  wire logic        crcOk,            // CRC passed
    output logic             infoValid,        // Parsed info held
    output logic      [5:0]  cteTime,          // Clamped duration, 8 us units
    output logic      [1:0]  cteType,          // Received extension type
    output logic             durationSuspect,  // Raw duration outside 2..20
    output logic             headerMatch,      // Masked pattern matched
    output logic      [2:0]  switchSpacing,    // Switching period spacing code
    output logic             sampleEnable      // Go sample and switch, pulse
);
    logic [31:0] conf_q;
    logic [1:0]  opMode_q;
    logic [2:0]  switchIval_q;
    logic [31:0] regRdata_q;
    ice_state_t  state_q;
    logic        infoValid_q;
    logic [5:0]  cteTime_q;
    logic [1:0]  cteType_q;
    logic        durationSuspect_q;
    logic        headerMatch_q;
    logic [2:0]  switchSpacing_q;
    logic        sampleEnable_q;

    logic        parseEn;
    logic        infoInS1;
    logic        crcFailSample;
    logic [1:0]  maxDurSel;
    logic [2:0]  shortSpacing;
    logic [2:0]  longSpacing;
    logic        dfActive;
    logic [7:0]  infoByte;
    logic        infoSrcValid;
    logic        accept;

    ice_parse_if pif ();

    assign parseEn       = conf_q[POS_PARSE_EN];
    assign infoInS1      = conf_q[POS_INFO_S1];
    assign crcFailSample = conf_q[POS_CRC_FAIL];
    assign maxDurSel     = conf_q[POS_MAXDUR +: 2];
    assign shortSpacing  = conf_q[POS_SHORT +: 3];
    assign longSpacing   = conf_q[POS_LONG +: 3];
    assign dfActive      = (opMode_q == OP_DEPART) || (opMode_q == OP_ARRIVE);

    // Second header byte when the location bit is set, else extended header info
    assign infoByte     = infoInS1 ? secondHeaderByte : advInfo;
    assign infoSrcValid = infoInS1 | advInfoValid;
    assign accept       = hdrStrobe & parseEn & dfActive & infoSrcValid;

    assign pif.hdrField = firstHeaderField;
    assign pif.pattern  = conf_q[POS_PAT +: 8];
    assign pif.mask     = conf_q[POS_MASK +: 8];
    assign pif.rawTime  = {1'b0, infoByte[4:0]};
    assign pif.limitSel = maxDurSel;

    ice_hdr_match u_match (
        .p (pif.matcher)
    );

    ice_dur_clamp u_clamp (
        .p (pif.clamper)
    );

    // Codes pass untouched; the sampler interprets 1..6 as 4 us down to 125 ns
    function automatic logic [2:0] pickSpacing(
        input logic [1:0] op,
        input logic [1:0] typ,
        input logic [2:0] sw,
        input logic [2:0] shortSp,
        input logic [2:0] longSp
    );
        logic [2:0] sel;
        sel = 3'h0;
        if (op == OP_DEPART) begin
            if (typ == TYPE_DEP_1US) begin
                sel = shortSp;
            end else if (typ == TYPE_DEP_2US) begin
                sel = longSp;
            end
        end else if (op == OP_ARRIVE) begin
            if (sw == SW_2US) begin
                sel = shortSp;
            end else if (sw == SW_4US) begin
                sel = longSp;
            end
        end
        return sel;
    endfunction

    // Register writes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            conf_q       <= CONF_RST;
            opMode_q     <= OP_RST;
            switchIval_q <= SWITCH_RST;
        end else if (regWrite) begin
            case (regAddr)
                OFF_INLINE_CONF: conf_q <= regWdata & CONF_WMASK;
                OFF_OP_MODE:     opMode_q <= regWdata[1:0];
                OFF_SWITCH:      switchIval_q <= regWdata[POS_SWITCH +: 3];
                default:         conf_q <= conf_q;
            endcase
        end
    end

    // Register reads; unmapped addresses return zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdata_q <= 32'h00000000;
        end else if (regRead) begin
            case (regAddr)
                OFF_INLINE_CONF: regRdata_q <= conf_q;
                OFF_OP_MODE:     regRdata_q <= {30'h00000000, opMode_q};
                OFF_SWITCH:      regRdata_q <= {21'h000000, switchIval_q, 8'h00};
                OFF_STATUS:      regRdata_q <= {17'h00000, state_q == ST_WAIT_CRC,
                                                switchSpacing_q, headerMatch_q,
                                                durationSuspect_q, infoValid_q,
                                                cteType_q, cteTime_q};
                default:         regRdata_q <= 32'h00000000;
            endcase
        end else begin
            regRdata_q <= 32'h00000000;
        end
    end

    // Packet sequencing: header, then CRC verdict
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_WAIT_CRC;
                    end
                end
                ST_WAIT_CRC: begin
                    // A new header restarts; a lost CRC cannot lock us up
                    if (accept) begin
                        state_q <= ST_WAIT_CRC;
                    end else if (hdrStrobe || crcStrobe) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Parsed info capture
    always_ff @(posedge clk) begin
        if (!rstn) begin
            infoValid_q       <= 1'b0;
            cteTime_q         <= 6'h00;
            cteType_q         <= 2'h0;
            durationSuspect_q <= 1'b0;
            switchSpacing_q   <= 3'h0;
        end else if (accept) begin
            infoValid_q       <= 1'b1;
            cteTime_q         <= pif.clampedTime;
            cteType_q         <= infoByte[POS_TYPE +: 2];
            durationSuspect_q <= pif.suspect;
            switchSpacing_q   <= pickSpacing(opMode_q, infoByte[POS_TYPE +: 2], switchIval_q,
                                             shortSpacing, longSpacing);
        end else if (hdrStrobe) begin
            // Packet info is ignored while parsing, op mode or the info source is off
            infoValid_q <= 1'b0;
        end
    end

    // Header pattern result, refreshed on every header
    always_ff @(posedge clk) begin
        if (!rstn) begin
            headerMatch_q <= 1'b0;
        end else if (hdrStrobe) begin
            headerMatch_q <= pif.hit;
        end
    end

    // Go decision on the CRC verdict
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sampleEnable_q <= 1'b0;
        end else begin
            sampleEnable_q <= (state_q == ST_WAIT_CRC) && crcStrobe && !hdrStrobe
                              && (crcOk || crcFailSample);
        end
    end

    assign regRdata        = regRdata_q;
    assign infoValid       = infoValid_q;
    assign cteTime         = cteTime_q;
    assign cteType         = cteType_q;
    assign durationSuspect = durationSuspect_q;
    assign headerMatch     = headerMatch_q;
    assign switchSpacing   = switchSpacing_q;
    assign sampleEnable    = sampleEnable_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence hdrTaken;
        accept;
    endsequence

    sequence crcSeen;
        (state_q == ST_WAIT_CRC) && crcStrobe && !hdrStrobe;
    endsequence

    parse_off_a: assert property (hdrStrobe && !parseEn |=> !infoValid_q)
        else $error("info taken while parsing disabled");

    info_src_a: assert property (hdrTaken and infoInS1 |=> cteType_q == $past(secondHeaderByte[7:6])
                                 && infoValid_q)
        else $error("type not taken from second header byte");

    crc_skip_a: assert property (crcSeen and (!crcOk && !crcFailSample) |=> !sampleEnable_q)
        else $error("sampling after CRC failure");

    // Waiting state already means a header was taken, so the verdict edge alone suffices
    crc_keep_a: assert property (crcSeen and crcFailSample
                                 |=> sampleEnable_q ##1 !sampleEnable_q)
        else $error("sampling missing after CRC verdict");

    clamp_exact_a: assert property (hdrTaken and (maxDurSel == 2'h0) && (advInfo[4:0] > 5'h14)
                                    && !infoInS1 |=> cteTime_q == LIM_DEFAULT)
        else $error("duration not clamped to 20");

    clamp_pass_a: assert property (hdrTaken and (maxDurSel == 2'h1) |=> cteTime_q == $past(pif.rawTime))
        else $error("duration changed under limit 31");

    suspect_flag_a: assert property (hdrTaken |=> durationSuspect_q == (($past(pif.rawTime) > 6'h14)
                                     || ($past(pif.rawTime) < 6'h02)))
        else $error("suspect flag wrong");

    spacing_dep_a: assert property (hdrTaken and (opMode_q == OP_DEPART) && (infoByte[7:6] == 2'h2)
                                    |=> switchSpacing_q == $past(longSpacing))
        else $error("departure long spacing not applied");

    spacing_arr_a: assert property (hdrTaken and (opMode_q == OP_ARRIVE) && (switchIval_q == 3'h2)
                                    |=> switchSpacing_q == $past(shortSpacing))
        else $error("arrival short spacing not applied");

    op_off_a: assert property (hdrStrobe && (opMode_q == 2'h0) |=> !infoValid_q
                               && (state_q == ST_IDLE))
        else $error("parsing while direction finding disabled");

    match_res_a: assert property (hdrStrobe |=> headerMatch_q == ((($past(firstHeaderField)
                                  ^ $past(conf_q[23:16])) & $past(conf_q[31:24])) == 8'h00))
        else $error("header match result wrong");

    read_conf_a: assert property (regRead && (regAddr == OFF_INLINE_CONF) && !regWrite
                                  |=> regRdata == $past(conf_q)
                                  ##1 ($past(regRead) || regRdata == 32'h00000000))
        else $error("config readback wrong");
endmodule
`default_nettype wire

// ---- ice_radio_model.sv ----
// Remote transmitter model: hands header and CRC events to the parser
`timescale 1ns/100ps
`default_nettype none
module ice_radio_model (
    input  wire logic       clk,              // Receiver clock
    output logic            hdrStrobe,        // Header bytes valid
    output logic      [7:0] firstHeaderField, // First header field
    output logic      [7:0] secondHeaderByte, // Second header byte
    output logic            advInfoValid,     // Extended header info present
    output logic      [7:0] advInfo,          // Extended header info byte
    output logic            crcStrobe,        // CRC verdict valid
    output logic            crcOk             // CRC passed
);
    initial begin
        hdrStrobe        = 1'h0;
        firstHeaderField = 8'h00;
        secondHeaderByte = 8'h00;
        advInfoValid     = 1'h0;
        advInfo          = 8'h00;
        crcStrobe        = 1'h0;
        crcOk            = 1'h0;
    end

    // Lines flip to the inverse after the strobe so a late sample is caught
    task automatic send_header(input logic [7:0] f0, input logic [7:0] b1, input logic av, input logic [7:0] adv);
        @(posedge clk);
        hdrStrobe        <= 1'h1;
        firstHeaderField <= f0;
        secondHeaderByte <= b1;
        advInfoValid     <= av;
        advInfo          <= adv;
        @(posedge clk);
        hdrStrobe        <= 1'h0;
        firstHeaderField <= ~f0;
        secondHeaderByte <= ~b1;
        advInfoValid     <= ~av;
        advInfo          <= ~adv;
    endtask

    task automatic send_crc(input logic ok);
        @(posedge clk);
        crcStrobe <= 1'h1;
        crcOk     <= ok;
        @(posedge clk);
        crcStrobe <= 1'h0;
        crcOk     <= ~ok;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the inline tone extension parser
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ice_pkg::*;
    typedef struct packed {
        logic en; logic s1b; logic [1:0] lim; logic [2:0] sht; logic [2:0] lng; logic [7:0] pat; logic [7:0] msk;
        logic [1:0] op; logic [2:0] sw; logic [7:0] f0; logic [7:0] b1; logic av; logic [7:0] adv;
    } ice_row_t;
    logic clk, rstn, regWrite, regRead, hdrStrobe, advInfoValid, crcStrobe, crcOk;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [7:0]  firstHeaderField, secondHeaderByte, advInfo;
    logic        infoValid, durationSuspect, headerMatch, sampleEnable;
    logic [5:0]  cteTime;
    logic [1:0]  cteType;
    logic [2:0]  switchSpacing;
    int          err_total, total_checks;
    ice_row_t rows [0:15] = '{
        '{1'h1,1'h1,2'h0,3'h1,3'h2,8'hA5,8'hFF,2'h2,3'h2,8'hA5,8'h59,1'h0,8'h00},
        '{1'h1,1'h1,2'h1,3'h3,3'h4,8'hA5,8'hFF,2'h2,3'h2,8'hA4,8'h99,1'h0,8'h00},
        '{1'h1,1'h1,2'h2,3'h5,3'h6,8'h00,8'h00,2'h2,3'h2,8'h33,8'h1F,1'h0,8'h00},
        '{1'h1,1'h1,2'h3,3'h6,3'h1,8'h00,8'h00,2'h2,3'h2,8'h00,8'h5E,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h5,3'h2,8'h00,8'h00,2'h2,3'h2,8'h00,8'h82,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h5,3'h2,8'h00,8'h00,2'h2,3'h2,8'h00,8'h54,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h5,3'h2,8'h00,8'h00,2'h2,3'h2,8'h00,8'h55,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h5,3'h2,8'h00,8'h00,2'h2,3'h2,8'h00,8'h41,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h2,3'h3,8'h00,8'h00,2'h3,3'h2,8'h00,8'h8A,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h2,3'h3,8'h00,8'h00,2'h3,3'h1,8'h00,8'h4A,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h2,3'h3,8'h00,8'h00,2'h3,3'h3,8'h00,8'h4A,1'h0,8'h00},
        '{1'h1,1'h1,2'h0,3'h1,3'h2,8'h0F,8'hF0,2'h0,3'h2,8'h03,8'h4A,1'h0,8'h00},
        '{1'h0,1'h1,2'h0,3'h1,3'h2,8'h00,8'h10,2'h2,3'h2,8'h10,8'h4A,1'h0,8'h00},
        '{1'h1,1'h0,2'h0,3'h1,3'h2,8'h00,8'h00,2'h2,3'h2,8'h00,8'h4A,1'h0,8'h00},
        '{1'h1,1'h0,2'h0,3'h4,3'h2,8'h00,8'h00,2'h2,3'h2,8'h00,8'h4A,1'h1,8'h9A},
        '{1'h1,1'h1,2'h0,3'h1,3'h2,8'h00,8'h00,2'h1,3'h2,8'h00,8'h4A,1'h0,8'h00}};

    ice_inline_cfg i_ice_inline_cfg (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .hdrStrobe(hdrStrobe),
        .firstHeaderField(firstHeaderField), .secondHeaderByte(secondHeaderByte), .advInfoValid(advInfoValid),
        .advInfo(advInfo), .crcStrobe(crcStrobe), .crcOk(crcOk), .infoValid(infoValid), .cteTime(cteTime),
        .cteType(cteType), .durationSuspect(durationSuspect), .headerMatch(headerMatch),
        .switchSpacing(switchSpacing), .sampleEnable(sampleEnable));
    ice_radio_model i_ice_radio_model (.clk(clk), .hdrStrobe(hdrStrobe), .firstHeaderField(firstHeaderField),
        .secondHeaderByte(secondHeaderByte), .advInfoValid(advInfoValid), .advInfo(advInfo),
        .crcStrobe(crcStrobe), .crcOk(crcOk));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'h1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask

    task automatic reg_read(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'h0;
        #1 check(regRdata, exp);
    endtask

    task automatic check_row(input ice_row_t r);
        logic acc;
        logic [4:0] raw;
        logic [1:0] typ;
        logic [5:0] lim;
        logic [2:0] sp;
        acc = r.en && r.op[1] && (r.s1b || r.av);
        raw = r.s1b ? r.b1[4:0] : r.adv[4:0];
        typ = r.s1b ? r.b1[7:6] : r.adv[7:6];
        lim = (r.lim == 2'h1) ? LIM_MID : (r.lim == 2'h2) ? LIM_MAX : LIM_DEFAULT;
        if (r.op == 2'h2) sp = (typ == TYPE_DEP_1US) ? r.sht : (typ == TYPE_DEP_2US) ? r.lng : 3'h0;
        else sp = (r.sw == SW_2US) ? r.sht : (r.sw == SW_4US) ? r.lng : 3'h0;
        check(infoValid, acc);
        check(headerMatch, ((r.f0 ^ r.pat) & r.msk) == 8'h00);
        if (acc) begin
            check(cteTime, ({1'h0, raw} > lim) ? lim : {1'h0, raw});
            check(cteType, typ);
            check(durationSuspect, raw > 5'h14 || raw < 5'h02);
            check(switchSpacing, sp);
        end
    endtask

    task automatic crc_case(input logic en, input logic errBit, input logic ok, input int gap);
        reg_write(OFF_INLINE_CONF, {CONF_RST[31:3], errBit, 1'h1, en});
        reg_write(OFF_OP_MODE, 32'h00000002);
        i_ice_radio_model.send_header(8'h00, 8'h4A, 1'h0, 8'h00);
        repeat (gap) @(posedge clk);
        #1 check(sampleEnable, 1'h0);
        i_ice_radio_model.send_crc(ok);
        #1 check(sampleEnable, en && (ok || errBit));
        @(posedge clk);
        #1 check(sampleEnable, 1'h0);
    endtask

    initial begin
        #50000;
        err_total++;
        report_and_stop();
    end

    initial begin
        rstn     = 1'h0;
        regWrite = 1'h0;
        regRead  = 1'h0;
        regAddr  = 12'h000;
        regWdata = 32'h00000000;
        err_total    = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        reg_read(OFF_INLINE_CONF, CONF_RST);
        @(posedge clk);
        #1 check(regRdata, 32'h00000000);
        reg_read(12'h908, 32'h00000000);
        reg_read(OFF_OP_MODE, {30'h0, OP_RST});
        reg_read(OFF_SWITCH, {21'h0, SWITCH_RST, 8'h00});
        reg_write(OFF_STATUS, 32'hFFFFFFFF);
        reg_read(OFF_STATUS, 32'h00000000);
        reg_write(OFF_INLINE_CONF, 32'hFFFFFFFF);
        reg_read(OFF_INLINE_CONF, CONF_WMASK);
        foreach (rows[i]) begin
            reg_write(OFF_INLINE_CONF, {rows[i].msk, rows[i].pat, rows[i].lng, rows[i].sht, 2'h0, rows[i].lim,
                                        3'h0, 1'h0, rows[i].s1b, rows[i].en});
            reg_write(OFF_OP_MODE, {30'h0, rows[i].op});
            reg_write(OFF_SWITCH, {21'h0, rows[i].sw, 8'h00});
            i_ice_radio_model.send_header(rows[i].f0, rows[i].b1, rows[i].av, rows[i].adv);
            #1 check_row(rows[i]);
        end
        // Last taken row clamped 26 to 20, type 2, long spacing; last header matched under a zero mask, not taken
        reg_read(OFF_STATUS, {17'h0, 1'h0, 3'h2, 1'h1, 1'h1, 1'h0, 2'h2, LIM_DEFAULT});
        crc_case(1'h1, 1'h1, 1'h0, 0);
        crc_case(1'h1, 1'h0, 1'h0, 2);
        crc_case(1'h1, 1'h0, 1'h1, 1);
        crc_case(1'h0, 1'h1, 1'h1, 0);
        // Reset again mid-run; state and config must both fall back
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        #1 check(infoValid, 1'h0);
        reg_read(OFF_INLINE_CONF, CONF_RST);
        report_and_stop();
    end
endmodule
`default_nettype wire
